// [inc/bank_legality_map.vh]
// Command encodings, bank state codes and timing counts for the bank tracker
`ifndef BANK_LEGALITY_MAP_VH
`define BANK_LEGALITY_MAP_VH

// Clock period in picoseconds (200 MHz)
`define CLK_PS 5000
// Timing figures in nanoseconds
`define T_RP_NS 18
`define T_RCD_NS 18
`define T_RC_NS 60
`define T_WR_NS 12
// Mode register delay in clock cycles
`define T_MRD_CYC 2
// Self refresh exit time in nanoseconds
`define T_XSR_NS 120
// Least times round up to whole cycles
`define CYC_UP(ns) (((ns) * 1000 + `CLK_PS - 1) / `CLK_PS)

// Command codes {ras_n, cas_n, we_n} with chip select low
`define CMD_NOP 3'b111
`define CMD_ACT 3'b011
`define CMD_RD 3'b101
`define CMD_WR 3'b100
`define CMD_BST 3'b110
`define CMD_PRE 3'b010
`define CMD_REF 3'b001
`define CMD_MRS 3'b000

// Bank state codes reported on the state outputs
`define ST_IDLE 3'h0
`define ST_ACTG 3'h1
`define ST_ACTV 3'h2
`define ST_READ 3'h3
`define ST_WRIT 3'h4
`define ST_RDAP 3'h5
`define ST_WRAP 3'h6
`define ST_PREC 3'h7

// Address bit that selects auto precharge or precharge-all
`define AP_BIT 10

`endif

// [hdl/bank_legality.v]
// Per-bank state tracking and command legality check for an SDRAM device
// Function
// RULE1: Legality checked only with clock enable held high
// RULE2: Idle only after precharge and row precharge time
// RULE3: Row active after activate plus activate delay
// RULE4: Reading or writing until burst ends or truncated
// RULE5: Controller issues nothing to busy timed bank; a precharge to a precharging bank is not flagged
// RULE6: Precharging lasts row precharge time, then idle
// RULE7: Read with auto precharge busy until precharged
// RULE8: Write with auto precharge busy until precharged
// RULE9: Refresh lasts row cycle time, only nops
// RULE10: Mode load lasts register delay, only nops
// RULE11: Precharge-all lasts row precharge time, only nops
// RULE12: Refresh and mode load need all idle
// RULE13: Precharge-all needs every bank prechargeable
// RULE14: Burst terminate stops most recent burst
// RULE15: Precharge to idle bank acts as nop
// RULE16: Decode commands from four strobes
// RULE17: Inhibit and nop let operations continue
// RULE18: Row active accepts read, write, precharge
// RULE19: Read burst accepts read, write, terminate, precharge
// RULE20: Write burst accepts read, write, terminate, precharge
// RULE21: Idle bank leaves other bank unconstrained
// RULE22: Other banks accept activate, read, write, precharge
// RULE23: Interrupted auto precharge burst starts precharging
// RULE24: Controller masks data before interrupting write; not checked, as the tracker has no data mask input
// RULE25: Interrupted auto precharge write waits recovery
// RULE26: Controller keeps per-bank state and timers
// RULE27: Undefined commands flagged as illegal
`include "bank_legality_map.vh"

module bank_legality #(
   parameter BANKS = 4,
   parameter BA_W = 2,
   parameter BURST_LEN = 4,
   parameter T_XSR_CYC = `CYC_UP(`T_XSR_NS)
) (
   input wire mclk,
   input wire nrst,
   input wire cke_pin,
   input wire cs_n_pin,
   input wire ras_n_pin,
   input wire cas_n_pin,
   input wire we_n_pin,
   input wire [BA_W-1:0] ba_pin,
   input wire ap_pin,
   output reg [3*BANKS-1:0] bank_state,
   output reg all_idle,
   output reg device_busy,
   output reg illegal_cmd,
   output reg burst_active
);

   // Cycle counts; timers keep the low bits, so counts stay below 256 (below 65536 for the self refresh exit count)
   localparam integer RP_INT = `CYC_UP(`T_RP_NS);
   localparam integer RCD_INT = `CYC_UP(`T_RCD_NS);
   localparam integer RC_INT = `CYC_UP(`T_RC_NS);
   localparam integer WR_INT = `CYC_UP(`T_WR_NS);
   localparam integer MRD_INT = `T_MRD_CYC;
   localparam integer BL_INT = BURST_LEN;
   localparam integer XSR_INT = T_XSR_CYC;
   localparam [7:0] RP_CYC = RP_INT[7:0];
   localparam [7:0] RCD_CYC = RCD_INT[7:0];
   localparam [7:0] RC_CYC = RC_INT[7:0];
   localparam [7:0] WR_CYC = WR_INT[7:0];
   localparam [7:0] MRD_CYC = MRD_INT[7:0];
   localparam [7:0] BL_CYC = BL_INT[7:0];
   localparam [15:0] XSR_CYC = XSR_INT[15:0];

   // Device-wide states, one-hot
   localparam [3:0] DV_OPEN = 4'b0001;
   localparam [3:0] DV_REFR = 4'b0010;
   localparam [3:0] DV_MODE = 4'b0100;
   localparam [3:0] DV_PALL = 4'b1000;

   // Two-flop synchronisers for every pin
   reg [5+BA_W:0] pin_s1_r;
   reg [5+BA_W:0] pin_s2_r;
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pin_s1_r <= {(6+BA_W){1'b1}};
         pin_s2_r <= {(6+BA_W){1'b1}};
      end else begin
         pin_s1_r <= {cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin,
                      ap_pin, ba_pin};
         pin_s2_r <= pin_s1_r;
      end
   end

   wire cke = pin_s2_r[5+BA_W];
   wire cs_n = pin_s2_r[4+BA_W];
   wire [2:0] cmd = pin_s2_r[3+BA_W:1+BA_W];
   wire ap = pin_s2_r[BA_W];
   wire [BA_W-1:0] ba = pin_s2_r[BA_W-1:0];

   // Previous clock enable, and self refresh exit holdoff
   reg cke_prev_r;
   reg [15:0] xsr_cnt_r;
   reg in_sref_r;

   // RULE16: strobe decode
   wire sel = !cs_n;
   wire is_act = sel && (cmd == `CMD_ACT);
   wire is_rd = sel && (cmd == `CMD_RD);
   wire is_wr = sel && (cmd == `CMD_WR);
   wire is_bst = sel && (cmd == `CMD_BST);
   wire is_pre = sel && (cmd == `CMD_PRE);
   wire is_ref = sel && (cmd == `CMD_REF);
   wire is_mrs = sel && (cmd == `CMD_MRS);
   // RULE17: inhibit or nop leaves state running
   wire is_quiet = cs_n || (cmd == `CMD_NOP);

   // RULE1: checking window
   wire check_en = cke && cke_prev_r && (xsr_cnt_r == 16'h0000);

   // Per-bank state and timer
   reg [2:0] st_r [0:BANKS-1];
   reg [7:0] tmr_r [0:BANKS-1];
   reg [2:0] st_nxt [0:BANKS-1];
   reg [7:0] tmr_nxt [0:BANKS-1];
   reg [3:0] dev_r;
   reg [3:0] dev_nxt;
   reg [7:0] dev_tmr_r;
   reg [7:0] dev_tmr_nxt;
   reg [BA_W-1:0] last_bank_r;
   reg [BA_W-1:0] last_bank_nxt;
   reg bad;
   reg idle_all;
   reg all_prechargeable;
   integer i;
   // Each clocked process has its own loop index
   integer j, k;

   // Timer step with floor at zero
   function [7:0] dec8;
      input [7:0] v;
      begin
         dec8 = (v == 8'h00) ? 8'h00 : v - 8'h01;
      end
   endfunction

   // True for states that accept no same-bank command, except precharge to a precharging bank
   function timed_state;
      input [2:0] s;
      begin
         timed_state = (s == `ST_ACTG) || (s == `ST_PREC) ||
                       (s == `ST_RDAP) || (s == `ST_WRAP);
      end
   endfunction

   // Next-state logic for banks and device
   always @* begin
      bad = 1'b0;
      dev_nxt = dev_r;
      dev_tmr_nxt = dec8(dev_tmr_r);
      last_bank_nxt = last_bank_r;
      idle_all = 1'b1;
      all_prechargeable = 1'b1;
      for (i = 0; i < BANKS; i = i + 1) begin
         st_nxt[i] = st_r[i];
         tmr_nxt[i] = dec8(tmr_r[i]);
         if (st_r[i] != `ST_IDLE)
            idle_all = 1'b0;
         // RULE13: precharge-all refused during timed states other than precharging
         if (timed_state(st_r[i]) && st_r[i] != `ST_PREC)
            all_prechargeable = 1'b0;
      end
      // Timed bank states expire
      for (i = 0; i < BANKS; i = i + 1) begin
         // RULE2: idle only when timer reaches zero
         if (tmr_r[i] == 8'h00) begin
            case (st_r[i])
               // RULE6: precharge completes
               `ST_PREC: st_nxt[i] = `ST_IDLE;
               // RULE3: activate delay met
               `ST_ACTG: st_nxt[i] = `ST_ACTV;
               // RULE4: burst completes on its own
               `ST_READ, `ST_WRIT: st_nxt[i] = `ST_ACTV;
               // RULE7: RULE8: auto precharge access ends in precharging
               `ST_RDAP, `ST_WRAP: begin
                  st_nxt[i] = `ST_PREC;
                  tmr_nxt[i] = RP_CYC - 8'h01;
               end
               default: st_nxt[i] = st_r[i];
            endcase
         end
      end
      // Device-wide timed states
      if (dev_r != DV_OPEN && dev_tmr_r == 8'h00) begin
         dev_nxt = DV_OPEN;
         if (dev_r == DV_PALL)
            for (i = 0; i < BANKS; i = i + 1)
               st_nxt[i] = `ST_IDLE;
      end
      if (check_en && !is_quiet) begin
         // RULE9: refresh and RULE10 / RULE11 hold only nops
         if (dev_r != DV_OPEN)
            bad = 1'b1;
         // RULE12: refresh and mode load need all idle
         else if (is_ref || is_mrs) begin
            if (!idle_all)
               bad = 1'b1;
            else begin
               dev_nxt = is_ref ? DV_REFR : DV_MODE;
               dev_tmr_nxt = (is_ref ? RC_CYC : MRD_CYC) - 8'h01;
            end
         end else if (is_pre && ap) begin
            if (!all_prechargeable)
               bad = 1'b1;
            else begin
               // RULE11: precharge-all timed state
               dev_nxt = DV_PALL;
               dev_tmr_nxt = RP_CYC - 8'h01;
               for (i = 0; i < BANKS; i = i + 1)
                  if (st_r[i] != `ST_IDLE) begin
                     st_nxt[i] = `ST_PREC;
                     tmr_nxt[i] = RP_CYC - 8'h01;
                  end
            end
         end else if (is_bst) begin
            // RULE14: terminate the most recent burst, any bank address
            if (st_r[last_bank_r] == `ST_READ ||
                st_r[last_bank_r] == `ST_WRIT)
               st_nxt[last_bank_r] = `ST_ACTV;
            else
               bad = 1'b1;
         end else begin
            // RULE21: only the addressed bank's state counts
            // RULE5: same-bank command into timed state is illegal, except precharge to a precharging bank
            if (timed_state(st_r[ba]) && !(is_pre && st_r[ba] == `ST_PREC))
               bad = 1'b1;
            else if (is_act) begin
               if (st_r[ba] == `ST_IDLE) begin
                  st_nxt[ba] = `ST_ACTG;
                  tmr_nxt[ba] = RCD_CYC - 8'h01;
               end else
                  bad = 1'b1;
            end else if (is_pre) begin
               // RULE15: precharge to idle bank is a nop
               if (st_r[ba] != `ST_IDLE && st_r[ba] != `ST_PREC) begin
                  // RULE19: RULE20: precharge truncates burst
                  st_nxt[ba] = `ST_PREC;
                  tmr_nxt[ba] = RP_CYC - 8'h01;
               end
            end else if (is_rd || is_wr) begin
               // RULE18: column access needs an open row
               if (st_r[ba] == `ST_IDLE)
                  bad = 1'b1;
               else begin
                  st_nxt[ba] = is_rd ? (ap ? `ST_RDAP : `ST_READ) :
                                       (ap ? `ST_WRAP : `ST_WRIT);
                  tmr_nxt[ba] = BL_CYC - 8'h01;
                  last_bank_nxt = ba;
                  // RULE22: other banks keep running; handle interrupts
                  for (i = 0; i < BANKS; i = i + 1) begin
                     if (i != ba) begin
                        // RULE23: interrupted read auto precharge
                        if (st_r[i] == `ST_RDAP) begin
                           st_nxt[i] = `ST_PREC;
                           tmr_nxt[i] = RP_CYC - 8'h01;
                        end
                        // RULE25: interrupted write waits recovery
                        if (st_r[i] == `ST_WRAP) begin
                           tmr_nxt[i] = WR_CYC - 8'h01;
                        end
                        // Plain bursts stop when another bank bursts
                        if (st_r[i] == `ST_READ || st_r[i] == `ST_WRIT)
                           st_nxt[i] = `ST_ACTV;
                     end
                  end
               end
            end else
               // RULE27: anything else undefined
               bad = 1'b1;
         end
      end
   end

   // State registers
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         for (j = 0; j < BANKS; j = j + 1) begin
            st_r[j] <= `ST_IDLE;
            tmr_r[j] <= 8'h00;
         end
         dev_r <= DV_OPEN;
         dev_tmr_r <= 8'h00;
         last_bank_r <= {BA_W{1'b0}};
         cke_prev_r <= 1'b1;
         in_sref_r <= 1'b0;
         xsr_cnt_r <= 16'h0000;
      end else begin
         cke_prev_r <= cke;
         // RULE1: self refresh entry and exit holdoff
         if (cke_prev_r && !cke && is_ref)
            in_sref_r <= 1'b1;
         else if (in_sref_r && cke) begin
            in_sref_r <= 1'b0;
            xsr_cnt_r <= XSR_CYC;
         end else if (xsr_cnt_r != 16'h0000)
            xsr_cnt_r <= xsr_cnt_r - 16'h0001;
         // Clock enable low freezes tracking (suspend or power down)
         if (cke && cke_prev_r) begin
            for (j = 0; j < BANKS; j = j + 1) begin
               st_r[j] <= st_nxt[j];
               tmr_r[j] <= tmr_nxt[j];
            end
            dev_r <= dev_nxt;
            dev_tmr_r <= dev_tmr_nxt;
            last_bank_r <= last_bank_nxt;
         end
      end
   end

   // Registered status outputs
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         bank_state <= {(3*BANKS){1'b0}};
         all_idle <= 1'b1;
         device_busy <= 1'b0;
         illegal_cmd <= 1'b0;
         burst_active <= 1'b0;
      end else begin
         for (k = 0; k < BANKS; k = k + 1)
            bank_state[3*k +: 3] <= st_r[k];
         all_idle <= idle_all && (dev_r == DV_OPEN);
         device_busy <= (dev_r != DV_OPEN);
         // RULE27: one-cycle flag per illegal command
         illegal_cmd <= bad;
         burst_active <= (st_r[last_bank_r] == `ST_READ) ||
                         (st_r[last_bank_r] == `ST_WRIT);
      end
   end

endmodule // bank_legality

// [bench/bank_legality_chk.sv]
// Checker of bank state sequencing at the tracker's ports
`include "bank_legality_map.vh"
module bank_legality_chk #(parameter BANKS = 4) (
   input logic mclk,
   input logic nrst,
   input logic cke_pin,
   input logic [3*BANKS-1:0] bank_state,
   input logic all_idle,
   input logic device_busy,
   input logic illegal_cmd
);
   timeunit 1ns;
   timeprecision 1ps;
   // Bank zero carries most of the bench traffic
   wire [2:0] b0 = bank_state[2:0];
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   a_act_delay: assert property ($changed(b0) && b0 == `ST_ACTG
      |-> (b0 == `ST_ACTG) [*3] ##[1:2] (b0 == `ST_ACTV))
      else $error("activate delay wrong");
   a_prec_time: assert property ($changed(b0) && b0 == `ST_PREC
      |-> (b0 == `ST_PREC) [*3] ##[1:2] (b0 == `ST_IDLE))
      else $error("precharge time wrong");
   a_idle_next: assert property (b0 == `ST_IDLE
      |=> b0 inside {`ST_IDLE, `ST_ACTG})
      else $error("idle bank left wrongly");
   a_burst_next: assert property (
      b0 inside {`ST_READ, `ST_WRIT} |=> !(b0 inside {`ST_IDLE, `ST_ACTG}))
      else $error("burst left wrongly");
   a_idle_all: assert property (all_idle |-> bank_state == '0)
      else $error("all idle with a bank busy");
   a_busy_idle: assert property (device_busy
      |=> device_busy || all_idle)
      else $error("banks not idle after device operation");
   a_busy_ends: assert property ($rose(device_busy)
      |-> ##[1:14] all_idle)
      else $error("device operation did not end");
   a_cke_quiet: assert property (!cke_pin [*6] |-> !illegal_cmd)
      else $error("command tracked with clock enable low");
endmodule // bank_legality_chk
bind bank_legality bank_legality_chk #(.BANKS(BANKS)) bank_legality_chk_i (
   .mclk(mclk), .nrst(nrst), .cke_pin(cke_pin), .bank_state(bank_state),
   .all_idle(all_idle), .device_busy(device_busy), .illegal_cmd(illegal_cmd));

// [bench/ctrl_model.sv]
// Controller model that drives command strobes into the tracker
`include "bank_legality_map.vh"
module ctrl_model (
   input logic mclk,
   output logic cke = 1'b1,
   output logic cs_n = 1'b1,
   output logic ras_n = 1'b1,
   output logic cas_n = 1'b1,
   output logic we_n = 1'b1,
   output logic [1:0] ba = 2'h0,
   output logic ap = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   // Bench tasks wait out bank timers; t_wide issues commands inside device timers to provoke illegal flags
   // No data bus is modelled, so no mask is raised
   task automatic issue(input logic k, s, input logic [2:0] c,
      input logic [1:0] b, input logic a);
      @(posedge mclk);
      {cke, cs_n, ras_n, cas_n, we_n, ba, ap} <= {k, s, c, b, a};
      @(posedge mclk);
      // Address flips on the nop so stale values show
      {cs_n, ras_n, cas_n, we_n, ba, ap} <= {1'b0, `CMD_NOP, ~b, ~a};
   endtask
endmodule // ctrl_model

// [bench/bank_legality_tb.sv]
// Self-checking bench for the bank state tracker
`include "bank_legality_map.vh"
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin \
   failures++; $display("mismatch %s exp %h got %h", n, e, a); end end
module bank_legality_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0, nrst = 1'b0;
   wire cke, cs_n, ras_n, cas_n, we_n, ap, idle, busy, ill, bact;
   wire [1:0] ba;
   wire [11:0] st;
   int failures = 0, comparisons = 0, ill_cnt = 0, ill_base = 0;
   // 200 MHz clock
   always #2.5 mclk = ~mclk;
   // Illegal pulses last one cycle, so they are counted as they pass
   always @(posedge mclk) if (ill === 1'b1) ill_cnt <= ill_cnt + 1;
   ctrl_model ctrl_model_i (.mclk(mclk), .cke(cke), .cs_n(cs_n),
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .ap(ap));
   // Long bursts let an early terminate show
   bank_legality #(.BURST_LEN(8)) bank_legality_i (.mclk(mclk),
      .nrst(nrst), .cke_pin(cke), .cs_n_pin(cs_n), .ras_n_pin(ras_n),
      .cas_n_pin(cas_n), .we_n_pin(we_n), .ba_pin(ba), .ap_pin(ap),
      .bank_state(st), .all_idle(idle), .device_busy(busy),
      .illegal_cmd(ill), .burst_active(bact));
   task automatic cmd(input logic [2:0] c, input int b, input logic a);
      ctrl_model_i.issue(1'b1, 1'b0, c, b[1:0], a);
   endtask
   // Bounded waits, then compare
   task automatic st_is(input int b, input logic [2:0] c, input int n);
      repeat (n) if (st[3*b +: 3] !== c) @(negedge mclk);
      `CHK("bank_state", c, st[3*b +: 3])
   endtask
   task automatic idle_is(input int n);
      repeat (n) if (idle !== 1'b1) @(negedge mclk);
      `CHK("all_idle", 1'b1, idle)
   endtask
   // Expects exactly e pulses since the previous call
   task automatic ill_is(input logic e);
      repeat (5) @(negedge mclk);
      `CHK("illegal_cmd", int'(e), ill_cnt - ill_base)
      ill_base = ill_cnt;
   endtask
   task automatic t_basic;
      cmd(`CMD_ACT, 0, 0);
      st_is(0, `ST_ACTG, 5);
      st_is(0, `ST_ACTV, 6);
      cmd(`CMD_RD, 0, 0);
      st_is(0, `ST_READ, 4);
      `CHK("burst_active", 1'b1, bact)
      cmd(`CMD_BST, 3, 0);
      st_is(0, `ST_ACTV, 4);
      cmd(`CMD_RD, 0, 0);
      cmd(`CMD_WR, 0, 0);
      st_is(0, `ST_WRIT, 6);
      cmd(`CMD_PRE, 0, 0);
      st_is(0, `ST_PREC, 4);
      st_is(0, `ST_IDLE, 6);
      ill_is(1'b0);
      $display("done basic");
   endtask
   task automatic t_ap;
      cmd(`CMD_ACT, 1, 0);
      st_is(1, `ST_ACTV, 10);
      cmd(`CMD_RD, 1, 1);
      st_is(1, `ST_RDAP, 4);
      st_is(1, `ST_IDLE, 24);
      cmd(`CMD_ACT, 0, 0);
      cmd(`CMD_ACT, 2, 0);
      st_is(2, `ST_ACTV, 10);
      cmd(`CMD_WR, 0, 1);
      cmd(`CMD_RD, 2, 0);
      st_is(2, `ST_READ, 4);
      `CHK("bank_state", `ST_WRAP, st[2:0])
      st_is(0, `ST_PREC, 5);
      st_is(0, `ST_IDLE, 6);
      cmd(`CMD_PRE, 2, 0);
      idle_is(10);
      // Read with auto precharge cut short by a read to another bank
      cmd(`CMD_ACT, 1, 0);
      cmd(`CMD_ACT, 3, 0);
      st_is(3, `ST_ACTV, 10);
      cmd(`CMD_RD, 1, 1);
      cmd(`CMD_RD, 3, 0);
      st_is(1, `ST_PREC, 4);
      cmd(`CMD_PRE, 3, 0);
      idle_is(10);
      $display("done auto precharge");
   endtask
   task automatic t_wide;
      cmd(`CMD_PRE, 1, 0);
      ill_is(1'b0);
      `CHK("bank_state", 12'h000, st)
      cmd(`CMD_REF, 0, 0);
      cmd(`CMD_ACT, 0, 0);
      ill_is(1'b1);
      `CHK("device_busy", 1'b1, busy)
      idle_is(16);
      cmd(`CMD_MRS, 0, 0);
      cmd(`CMD_ACT, 0, 0);
      ill_is(1'b1);
      `CHK("bank_state", 12'h000, st)
      idle_is(8);
      cmd(`CMD_ACT, 3, 0);
      st_is(3, `ST_ACTV, 10);
      cmd(`CMD_REF, 0, 0);
      ill_is(1'b1);
      cmd(`CMD_PRE, 0, 1);
      idle_is(12);
      $display("done device wide");
   endtask
   task automatic t_cke;
      repeat (4) ctrl_model_i.issue(1'b0, 1'b0, `CMD_ACT, 2'h0, 1'b0);
      ctrl_model_i.issue(1'b1, 1'b1, `CMD_ACT, 2'h0, 1'b0);
      ill_is(1'b0);
      `CHK("bank_state", 12'h000, st)
      // Self refresh entry, then a command inside the exit holdoff
      ctrl_model_i.issue(1'b0, 1'b0, `CMD_REF, 2'h0, 1'b0);
      ctrl_model_i.issue(1'b1, 1'b1, `CMD_NOP, 2'h0, 1'b0);
      cmd(`CMD_ACT, 0, 0);
      ill_is(1'b0);
      `CHK("bank_state", 12'h000, st)
      repeat (24) @(negedge mclk);
      cmd(`CMD_ACT, 0, 0);
      ctrl_model_i.issue(1'b1, 1'b1, `CMD_PRE, 2'h0, 1'b0);
      st_is(0, `ST_ACTV, 8);
      ill_is(1'b0);
      cmd(`CMD_PRE, 0, 0);
      idle_is(10);
      $display("done clock enable");
   endtask
   task automatic give_verdict;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Reset checks, then the scenarios in turn
   initial begin
      repeat (10) @(posedge mclk);
      `CHK("bank_state", 12'h000, st)
      `CHK("all_idle", 1'b1, idle)
      nrst <= 1'b1;
      t_basic;
      t_ap;
      t_wide;
      t_cke;
      give_verdict;
   end
   // Scenarios need well under a thousand cycles
   initial begin
      #20000;
      failures++;
      give_verdict;
   end
endmodule // bank_legality_tb
